// *** rtl/eesg_guard.v ***
/*
  Enclave extended-state guard: checks the feature request mask and frame
  size at create, checks entry and resume, swaps the feature-enable control
  with a shadow, saves and synthesises state on asynchronous exit, and
  produces report and key-selection values. Assumes an APB master on pclk.
*/
// What this block does
// - mask bits one and zero must be three
// - no extended save: upper mask bits zero
// - extended save: mask must be legal control value
// - frame page count covers all regions
// - legacy region 576 bytes, mask at 512
// - region length from walk over mask bits
// - region at byte zero, non-compacted
// - misc region just before register region
// - create faults when low mask bits wrong
// - legacy create faults upper bits or zero pages
// - create faults bad load, bit 63, small
// - entry faults on enables or non-subset mask
// - resume applies the same entry checks
// - entry shadows control, loads mask
// - resume shadows control, loads mask
// - exit saves mask-enabled state to region
// - present vector zero where mask zero
// - exit restores control, initialises state
// - resume restores with control equal mask
// - resume faults on bad saved data
// - resume marks all restored state modified
// - report carries mask; key uses selections
`timescale 1ns/1ps
`include "eesg_regs.vh"

module eesg_guard #(
  parameter        XSAVE_SUPPORT = 1,
  parameter [63:0] FEC_SUPPORTED = 64'h0000_0000_0000_00FF,
  parameter [31:0] SIMD_VALID    = 32'h0000_FFFF,
  parameter [31:0] GPR_BYTES     = 32'h0000_00B8,
  parameter [31:0] MISC_BYTES    = 32'h0000_0010,
  parameter [31:0] COMP_STRIDE   = 32'h0000_0040
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  output reg         gp_fault,
  output reg         op_done,
  output reg         in_enclave
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SIZE = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  reg  [1:0]  state;
  reg  [2:0]  ctrl;
  reg  [63:0] fec;
  reg  [63:0] mask;
  reg  [15:0] frame_pages;
  reg  [31:0] misc_sel;
  reg  [63:0] shadow;
  reg  [63:0] spv;
  reg  [31:0] hdr;
  reg  [31:0] simd;
  reg  [63:0] used;
  reg  [31:0] req_size;
  reg  [31:0] mask_copy;
  reg  [63:0] key_sel;
  reg  [31:0] key_msel;
  reg  [63:0] key_attr;
  reg  [31:0] key_misc;
  reg  [63:0] rpt_mask;
  reg  [31:0] rpt_misc;
  reg         fault;
  reg         done_flag;
  reg  [2:0]  last_op;
  reg         size_start;
  reg  [31:0] next_rdata;
  reg         next_err;

  wire        size_busy;
  wire        size_done;
  wire [31:0] xs_size;
  wire        setup   = psel && !penable;
  wire        wr_acc  = psel && penable && pwrite;
  wire        busy    = state != ST_IDLE;
  wire        xs      = XSAVE_SUPPORT != 0;
  wire        fxsr    = ctrl[`EESG_CTRL_FXSR];
  wire        osxs    = ctrl[`EESG_CTRL_XSAVE];
  wire [2:0]  cmd_op  = pwdata[2:0];
  wire        cmd_wr  = wr_acc && paddr == `EESG_CMD && !busy;

  // --------------------------------------------------------------------------
  // Consistency checks
  // --------------------------------------------------------------------------
  // A control value is loadable when it keeps bit 0, needs bit 1 for bit 2
  // and names only implemented components.
  function fec_legal;
    input [63:0] v;
    begin
      fec_legal = v[0] && !(v[2] && !v[1]) && ((v & ~FEC_SUPPORTED) == 64'h0);
    end
  endfunction

  wire        low_bad   = mask[1:0] != `EESG_BASE_MASK;
  wire        legacy_bad = (|mask[63:2]) || frame_pages == 16'h0;
  wire        xs_bad    = !fec_legal(mask) || mask[63];
  wire        mask_is3  = mask == {62'h0, `EESG_BASE_MASK};
  wire        entry_bad = !fxsr || (xs && ((!osxs && !mask_is3) ||
                          ((mask & fec) != mask)));
  // Saved-data checks hold whatever the OS extended-save enable says
  wire        rest_bad  = ((spv & ~mask) != 64'h0) || hdr != 32'h0 ||
                          ((simd & ~SIMD_VALID) != 32'h0);
  // Regions: extended state at zero, misc, then register region
  wire [31:0] frame_bytes = {4'h0, frame_pages, {`EESG_PAGE_SHIFT{1'b0}}};
  wire [31:0] misc_len    = (misc_sel[0]) ? MISC_BYTES : 32'h0;
  wire [31:0] need_bytes  = xs_size + misc_len + GPR_BYTES;
  wire        frame_small = need_bytes > frame_bytes;

  eesg_xsave_size #(
    .COMP_BASE   (`EESG_LEGACY_BYTES),
    .COMP_STRIDE (COMP_STRIDE)
  ) u_size (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (size_start),
    .mask    (mask),
    .busy    (size_busy),
    .done    (size_done),
    .size    (xs_size)
  );

  // --------------------------------------------------------------------------
  // Operation sequencer
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      fec        <= `EESG_FEC_RESET;
      shadow     <= `EESG_FEC_RESET;
      spv        <= 64'h0;
      used       <= 64'h0;
      req_size   <= 32'h0;
      mask_copy  <= 32'h0;
      key_attr   <= 64'h0;
      key_misc   <= 32'h0;
      rpt_mask   <= 64'h0;
      rpt_misc   <= 32'h0;
      fault      <= 1'b0;
      done_flag  <= 1'b0;
      last_op    <= `EESG_OP_NONE;
      size_start <= 1'b0;
      gp_fault   <= 1'b0;
      op_done    <= 1'b0;
      in_enclave <= 1'b0;
    end else begin
      gp_fault   <= 1'b0;
      op_done    <= 1'b0;
      size_start <= 1'b0;
      // Software load of the control register; illegal values fault instead
      if (wr_acc && !busy && !in_enclave &&
          (paddr == `EESG_FEC_LO || paddr == `EESG_FEC_HI)) begin
        if (fec_legal(paddr == `EESG_FEC_LO ? {fec[63:32], pwdata} : {pwdata, fec[31:0]})) begin
          if (paddr == `EESG_FEC_LO)
            fec[31:0] <= pwdata;
          else
            fec[63:32] <= pwdata;
        end else begin
          fault    <= 1'b1;
          gp_fault <= 1'b1;
        end
      end
      if (wr_acc && !busy && paddr == `EESG_SPV_LO)
        spv[31:0] <= pwdata;
      if (wr_acc && !busy && paddr == `EESG_SPV_HI)
        spv[63:32] <= pwdata;
      if (wr_acc && !busy && paddr == `EESG_USED_LO)
        used[31:0] <= pwdata;
      if (wr_acc && !busy && paddr == `EESG_USED_HI)
        used[63:32] <= pwdata;
      case (state)
        ST_IDLE: begin
          if (cmd_wr) begin
            last_op   <= cmd_op;
            fault     <= 1'b0;
            done_flag <= 1'b0;
            case (cmd_op)
              `EESG_OP_CREATE: begin
                if (low_bad || (!xs && legacy_bad) || (xs && xs_bad)) begin
                  fault    <= 1'b1;
                  gp_fault <= 1'b1;
                  op_done  <= 1'b1;
                  done_flag <= 1'b1;
                end else if (xs) begin
                  size_start <= 1'b1;
                  state      <= ST_SIZE;
                end else begin
                  req_size  <= `EESG_LEGACY_BYTES;
                  op_done   <= 1'b1;
                  done_flag <= 1'b1;
                end
              end
              `EESG_OP_ENTER, `EESG_OP_RESUME: begin
                if (in_enclave || entry_bad ||
                    (cmd_op == `EESG_OP_RESUME && rest_bad)) begin
                  fault    <= 1'b1;
                  gp_fault <= 1'b1;
                end else begin
                  shadow     <= fec;
                  fec        <= mask;
                  in_enclave <= 1'b1;
                  // Restored state counts as modified so a later optimised
                  // save cannot skip it.
                  if (cmd_op == `EESG_OP_RESUME)
                    used <= mask;
                end
                op_done   <= 1'b1;
                done_flag <= 1'b1;
              end
              `EESG_OP_AEX: begin
                if (in_enclave) begin
                  spv        <= used & mask;
                  fec        <= shadow;
                  used       <= 64'h0;
                  in_enclave <= 1'b0;
                  if (!xs)
                    mask_copy <= mask[31:0];
                end
                op_done   <= 1'b1;
                done_flag <= 1'b1;
              end
              `EESG_OP_REPORT: begin
                rpt_mask  <= mask;
                rpt_misc  <= misc_sel;
                op_done   <= 1'b1;
                done_flag <= 1'b1;
              end
              `EESG_OP_KEY: begin
                key_attr  <= mask & key_sel;
                key_misc  <= misc_sel & key_msel;
                op_done   <= 1'b1;
                done_flag <= 1'b1;
              end
              default: begin
                op_done   <= 1'b1;
                done_flag <= 1'b1;
              end
            endcase
          end
        end
        ST_SIZE: begin
          if (size_busy)
            state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (size_done)
            state <= ST_IDLE;
          if (size_done) begin
            req_size  <= need_bytes;
            op_done   <= 1'b1;
            done_flag <= 1'b1;
            if (frame_small) begin
              fault    <= 1'b1;
              gp_fault <= 1'b1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Plain software registers
  // --------------------------------------------------------------------------
  // Operands are frozen while an operation runs so the size walk sees a
  // steady mask.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl        <= 3'h0;
      mask        <= {62'h0, `EESG_BASE_MASK};
      frame_pages <= 16'h0;
      misc_sel    <= 32'h0;
      hdr         <= 32'h0;
      simd        <= 32'h0;
      key_sel     <= 64'h0;
      key_msel    <= 32'h0;
    end else if (wr_acc && !busy) begin
      case (paddr)
        `EESG_CTRL:    ctrl        <= pwdata[2:0];
        `EESG_MASK_LO: mask[31:0]  <= pwdata;
        `EESG_MASK_HI: mask[63:32] <= pwdata;
        `EESG_FRAME:   frame_pages <= pwdata[15:0];
        `EESG_MISC:    misc_sel    <= pwdata;
        `EESG_HDR:     hdr         <= pwdata;
        `EESG_SIMD:    simd        <= pwdata;
        `EESG_KSEL_LO: key_sel[31:0]  <= pwdata;
        `EESG_KSEL_HI: key_sel[63:32] <= pwdata;
        `EESG_KMSEL:   key_msel    <= pwdata;
        default:       ctrl        <= ctrl;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // APB read path
  // --------------------------------------------------------------------------
  assign pready = 1'b1;

  always @* begin
    next_err = 1'b0;
    case (paddr)
      `EESG_CTRL:     next_rdata = {29'h0, ctrl};
      `EESG_FEC_LO:   next_rdata = fec[31:0];
      `EESG_FEC_HI:   next_rdata = fec[63:32];
      `EESG_MASK_LO:  next_rdata = mask[31:0];
      `EESG_MASK_HI:  next_rdata = mask[63:32];
      `EESG_FRAME:    next_rdata = {16'h0, frame_pages};
      `EESG_MISC:     next_rdata = misc_sel;
      `EESG_CMD:      next_rdata = {29'h0, last_op};
      `EESG_STATUS:   next_rdata = {16'h0, `EESG_GP_ERR_CODE, 1'b0, last_op,
                                    done_flag, in_enclave, fault, busy};
      `EESG_SHD_LO:   next_rdata = shadow[31:0];
      `EESG_SHD_HI:   next_rdata = shadow[63:32];
      `EESG_SPV_LO:   next_rdata = spv[31:0];
      `EESG_SPV_HI:   next_rdata = spv[63:32];
      `EESG_HDR:      next_rdata = hdr;
      `EESG_SIMD:     next_rdata = simd;
      `EESG_USED_LO:  next_rdata = used[31:0];
      `EESG_USED_HI:  next_rdata = used[63:32];
      `EESG_REQSZ:    next_rdata = req_size;
      `EESG_MCOPY:    next_rdata = mask_copy;
      `EESG_KSEL_LO:  next_rdata = key_sel[31:0];
      `EESG_KSEL_HI:  next_rdata = key_sel[63:32];
      `EESG_KMSEL:    next_rdata = key_msel;
      `EESG_KEY_LO:   next_rdata = key_attr[31:0];
      `EESG_KEY_HI:   next_rdata = key_attr[63:32];
      `EESG_KMISC:    next_rdata = key_misc;
      `EESG_RPT_LO:   next_rdata = rpt_mask[31:0];
      `EESG_RPT_HI:   next_rdata = rpt_mask[63:32];
      `EESG_RPT_MISC: next_rdata = rpt_misc;
      default: begin
        next_rdata = 32'h0;
        next_err   = 1'b1;
      end
    endcase
  end

  // Read data and error are captured in the setup cycle so the access
  // cycle answers at once with no wait state.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0 : next_rdata;
      pslverr <= next_err;
    end
  end

endmodule

// *** rtl/eesg_regs.vh ***
/*
  Register offsets, field positions, reset values and fixed counts of the
  enclave extended-state guard. Included by the guard and its size engine.
*/
`ifndef EESG_REGS_VH
`define EESG_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define EESG_CTRL      8'h00
`define EESG_FEC_LO    8'h04
`define EESG_FEC_HI    8'h08
`define EESG_MASK_LO   8'h0C
`define EESG_MASK_HI   8'h10
`define EESG_FRAME     8'h14
`define EESG_MISC      8'h18
`define EESG_CMD       8'h1C
`define EESG_STATUS    8'h20
`define EESG_SHD_LO    8'h24
`define EESG_SHD_HI    8'h28
`define EESG_SPV_LO    8'h2C
`define EESG_SPV_HI    8'h30
`define EESG_HDR       8'h34
`define EESG_SIMD      8'h38
`define EESG_USED_LO   8'h3C
`define EESG_USED_HI   8'h40
`define EESG_REQSZ     8'h44
`define EESG_MCOPY     8'h48
`define EESG_KSEL_LO   8'h4C
`define EESG_KSEL_HI   8'h50
`define EESG_KMSEL     8'h54
`define EESG_KEY_LO    8'h58
`define EESG_KEY_HI    8'h5C
`define EESG_KMISC     8'h60
`define EESG_RPT_LO    8'h64
`define EESG_RPT_HI    8'h68
`define EESG_RPT_MISC  8'h6C

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define EESG_CTRL_FXSR   0
`define EESG_CTRL_XSAVE  1
`define EESG_CTRL_MODE64 2

// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define EESG_ST_BUSY     0
`define EESG_ST_FAULT    1
`define EESG_ST_ENCLAVE  2
`define EESG_ST_DONE     3
`define EESG_ST_OP_LSB   4
`define EESG_ST_ERR_LSB  8

// ----------------------------------------------------------------------------
// Operation codes written to CMD
// ----------------------------------------------------------------------------
`define EESG_OP_NONE     3'h0
`define EESG_OP_CREATE   3'h1
`define EESG_OP_ENTER    3'h2
`define EESG_OP_RESUME   3'h3
`define EESG_OP_AEX      3'h4
`define EESG_OP_REPORT   3'h5
`define EESG_OP_KEY      3'h6

// ----------------------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------------------
`define EESG_BASE_MASK     2'h3
`define EESG_LEGACY_BYTES  32'h0000_0240
`define EESG_MASK_COPY_OFS 32'h0000_0200
`define EESG_PAGE_SHIFT    12
`define EESG_GP_ERR_CODE   8'h00
`define EESG_FEC_RESET     64'h0000_0000_0000_0003
`define EESG_FIRST_COMP    6'h02
`define EESG_LAST_COMP     6'h3F

`endif

// *** rtl/eesg_xsave_size.v ***
/*
  Iterative length engine for the extended-state region: one mask bit per
  clock from component 2 to 63. Assumes the mask is held steady while busy.
*/
`timescale 1ns/1ps
`include "eesg_regs.vh"

module eesg_xsave_size #(
  parameter [31:0] COMP_BASE   = 32'h0000_0240,
  parameter [31:0] COMP_STRIDE = 32'h0000_0040
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        start,
  input  wire [63:0] mask,
  output reg         busy,
  output reg         done,
  output reg  [31:0] size
);

  reg  [5:0]  idx;
  reg  [31:0] offset;
  reg  [31:0] size_last;
  wire [31:0] comp_ofs;
  wire [31:0] run_end;

  // Component layout is linear; each entry starts COMP_STRIDE past the last
  assign comp_ofs = COMP_BASE + COMP_STRIDE * ({26'h0, idx} - 32'h2);
  assign run_end  = offset + size_last;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      size      <= 32'h0;
      idx       <= 6'h0;
      offset    <= 32'h0;
      size_last <= 32'h0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy      <= 1'b1;
        idx       <= `EESG_FIRST_COMP;
        offset    <= `EESG_LEGACY_BYTES;
        size_last <= 32'h0;
      end else if (busy) begin
        if (mask[idx] && comp_ofs >= run_end) begin
          offset    <= comp_ofs;
          size_last <= COMP_STRIDE;
        end
        if (idx == `EESG_LAST_COMP) begin
          busy <= 1'b0;
          done <= 1'b1;
          if (mask[idx] && comp_ofs >= run_end)
            size <= comp_ofs + COMP_STRIDE;
          else
            size <= run_end;
        end
        idx <= idx + 6'h1;
      end
    end
  end

endmodule

// *** verif/eesg_guard_chk.sv ***
/*
  Port checker for the enclave extended-state guard.
  Assumes it is bound to eesg_guard and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "eesg_regs.vh"

module eesg_guard_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        gp_fault,
  input wire logic        op_done,
  input wire logic        in_enclave
);
  wire cmd_wr = psel && penable && pwrite && (paddr == `EESG_CMD);
  wire aex_wr = cmd_wr && (pwdata[2:0] == `EESG_OP_AEX);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // --------------------------------------------------------------------------
  // Command steps
  // --------------------------------------------------------------------------
  sequence s_cmd(logic [2:0] op);
    cmd_wr && (pwdata[2:0] == op);
  endsequence
  sequence s_clean;
    op_done && !gp_fault;
  endsequence

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_enter_inside_faults: assert property (in_enclave ##0 s_cmd(`EESG_OP_ENTER) |=> gp_fault && op_done)
    else $error("enter inside an enclave did not fault");
  a_resume_inside_faults: assert property (in_enclave ##0 s_cmd(`EESG_OP_RESUME) |=> gp_fault && op_done)
    else $error("resume inside an enclave did not fault");
  a_enter_ok_inside: assert property (!in_enclave ##0 s_cmd(`EESG_OP_ENTER) ##1 s_clean |-> in_enclave)
    else $error("clean enter left the core outside");
  a_resume_ok_inside: assert property (!in_enclave ##0 s_cmd(`EESG_OP_RESUME) ##1 s_clean |-> in_enclave)
    else $error("clean resume left the core outside");
  a_entry_has_cause: assert property ($rose(in_enclave) |-> s_clean)
    else $error("enclave mode set without a clean completion");
  a_exit_leaves: assert property (in_enclave && aex_wr |=> s_clean ##0 !in_enclave)
    else $error("asynchronous exit did not leave the enclave");
  a_stay_inside: assert property (in_enclave && !aex_wr |=> in_enclave)
    else $error("enclave mode dropped without an exit");
  a_fault_pulse: assert property (gp_fault |=> !gp_fault)
    else $error("fault flag longer than one cycle");
  a_done_pulse: assert property (op_done |=> !op_done)
    else $error("completion flag longer than one cycle");
  a_fault_done: assert property (cmd_wr ##1 gp_fault |-> op_done)
    else $error("command fault without completion");
  a_create_bound: assert property (s_cmd(`EESG_OP_CREATE) |-> ##[1:80] op_done)
    else $error("create did not complete in time");
endmodule

bind eesg_guard eesg_guard_chk i_chk (
  .pclk       (pclk),
  .presetn    (presetn),
  .psel       (psel),
  .penable    (penable),
  .pwrite     (pwrite),
  .paddr      (paddr),
  .pwdata     (pwdata),
  .pready     (pready),
  .prdata     (prdata),
  .pslverr    (pslverr),
  .gp_fault   (gp_fault),
  .op_done    (op_done),
  .in_enclave (in_enclave)
);

// *** verif/eesg_guard_test.sv ***
/*
  Self-checking bench for the enclave extended-state guard.
  Assumes the software model drives APB; expectations are queued and a monitor compares.
*/
`timescale 1ns/1ps
`include "eesg_regs.vh"

module eesg_guard_test;
  logic        pclk;
  logic        presetn;
  wire         psel;
  wire         penable;
  wire         pwrite;
  wire  [7:0]  paddr;
  wire  [31:0] pwdata;
  wire         pready;
  wire  [31:0] prdata;
  wire         pslverr;
  wire         gp_fault;
  wire         op_done;
  wire         in_enclave;
  int          n_mismatch;
  int          checks_done;
  logic [32:0] q_rd[$];
  logic [1:0]  q_op[$];
  logic [31:0] r;
  // Create table: low mask, high mask, pages, expected fault
  logic [31:0] ml[6] = '{32'h1, 32'h203, 32'h3, 32'h7, 32'h3, 32'h7};
  logic [31:0] mh[6] = '{32'h0, 32'h0, 32'h8000_0000, 32'h0, 32'h0, 32'h0};
  logic [31:0] pg[6] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h1, 32'h1};
  logic        cf[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  eesg_guard i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .gp_fault(gp_fault), .op_done(op_done), .in_enclave(in_enclave));
  eesg_sw_model i_sw (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  // --------------------------------------------------------------------------
  // Comparison, monitor and closing
  // --------------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  always @(posedge pclk) begin : mon
    logic [32:0] e;
    logic [1:0]  o;
    if (psel && penable && !pwrite && pready && q_rd.size() != 0) begin
      e = q_rd.pop_front();
      if (e[32]) check({31'h0, pslverr}, 32'h1, "slave error");
      else check(prdata, e[31:0], "read data");
    end
    if (op_done) begin
      if (q_op.size() == 0) check(32'h0, 32'h1, "unexpected completion");
      else begin
        o = q_op.pop_front();
        check({31'h0, gp_fault}, {31'h0, o[0]}, "fault flag");
        check({31'h0, in_enclave}, {31'h0, o[1]}, "enclave mode");
      end
    end
  end

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Bus and command helpers
  // --------------------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_sw.xfer(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    q_rd.push_back({1'b0, exp});
    i_sw.xfer(1'b0, a, 32'h0);
  endtask

  // f holds the expected enclave mode in bit 1 and the expected fault in bit 0
  task op(input logic [2:0] c, input logic [1:0] f);
    int n;
    q_op.push_back(f);
    wr(`EESG_CMD, {29'h0, c});
    n = 0;
    while (q_op.size() != 0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n == 100) begin
      n_mismatch++;
      $display("[FAIL] %0t command %0d gave no completion", $time, c);
    end
  endtask

  initial begin
    #2_000_000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    void'($urandom(32'hD638A750));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`EESG_FEC_LO, 32'h3);
    rd(`EESG_SHD_LO, 32'h3);
    q_rd.push_back({1'b1, 32'h0});
    i_sw.xfer(1'b0, 8'hF0, 32'h0);
    $display("test reset done");
    wr(`EESG_CTRL, 32'h3);
    for (int i = 0; i < 6; i++) begin
      wr(`EESG_MASK_LO, ml[i]);
      wr(`EESG_MASK_HI, mh[i]);
      wr(`EESG_FRAME, pg[i]);
      op(`EESG_OP_CREATE, {1'b0, cf[i]});
    end
    // Region 576 plus one 64-byte component, then the 184-byte register region
    rd(`EESG_REQSZ, 32'h338);
    $display("test create done");
    wr(`EESG_CTRL, 32'h0);
    op(`EESG_OP_ENTER, 2'b01);
    wr(`EESG_CTRL, 32'h1);
    op(`EESG_OP_ENTER, 2'b01);
    wr(`EESG_CTRL, 32'h3);
    op(`EESG_OP_ENTER, 2'b01);
    wr(`EESG_FEC_LO, 32'hF);
    op(`EESG_OP_ENTER, 2'b10);
    rd(`EESG_STATUS, 32'h0000_002C);
    rd(`EESG_FEC_LO, 32'h7);
    rd(`EESG_SHD_LO, 32'hF);
    op(`EESG_OP_ENTER, 2'b11);
    op(`EESG_OP_RESUME, 2'b11);
    $display("test enter done");
    r = $urandom;
    wr(`EESG_USED_LO, r);
    wr(`EESG_USED_HI, $urandom);
    op(`EESG_OP_AEX, 2'b00);
    rd(`EESG_SPV_LO, r & 32'h7);
    rd(`EESG_SPV_HI, 32'h0);
    rd(`EESG_FEC_LO, 32'hF);
    rd(`EESG_USED_LO, 32'h0);
    $display("test exit done");
    wr(`EESG_SPV_LO, 32'h8);
    op(`EESG_OP_RESUME, 2'b01);
    wr(`EESG_SPV_LO, r & 32'h7);
    wr(`EESG_HDR, 32'h1);
    op(`EESG_OP_RESUME, 2'b01);
    wr(`EESG_HDR, 32'h0);
    wr(`EESG_SIMD, 32'h0001_0000);
    op(`EESG_OP_RESUME, 2'b01);
    wr(`EESG_SIMD, 32'h0);
    wr(`EESG_CTRL, 32'h0);
    op(`EESG_OP_RESUME, 2'b01);
    wr(`EESG_CTRL, 32'h1);
    op(`EESG_OP_RESUME, 2'b01);
    wr(`EESG_CTRL, 32'h3);
    op(`EESG_OP_RESUME, 2'b10);
    rd(`EESG_FEC_LO, 32'h7);
    rd(`EESG_SHD_LO, 32'hF);
    rd(`EESG_USED_LO, 32'h7);
    op(`EESG_OP_AEX, 2'b00);
    $display("test resume done");
    wr(`EESG_MISC, 32'h5);
    wr(`EESG_KSEL_LO, 32'h5);
    wr(`EESG_KMSEL, 32'h4);
    op(`EESG_OP_REPORT, 2'b00);
    rd(`EESG_RPT_LO, 32'h7);
    rd(`EESG_RPT_MISC, 32'h5);
    op(`EESG_OP_KEY, 2'b00);
    rd(`EESG_KEY_LO, 32'h5);
    rd(`EESG_KMISC, 32'h4);
    $display("test report done");
    repeat (3) @(posedge pclk);
    end_sim();
  end
endmodule

// *** verif/eesg_sw_model.sv ***
/*
  Software side of the guard: an APB master that issues register and
  command transfers. Assumes pready is answered by the guard on pclk.
*/
`timescale 1ns/1ps

module eesg_sw_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  // --------------------------------------------------------------------------
  // Bus idle state
  // --------------------------------------------------------------------------
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // --------------------------------------------------------------------------
  // One transfer: setup, access held until pready
  // --------------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines show garbage, so stale values never look valid
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule
